// ---- tb_top.sv ----
`timescale 1ns/10ps

module tb_top
  import tca_pkg::*;
;
  logic clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r, v;
  logic pready, pslverr, irq, err;
  logic [3:0] pin = 0, srcs = 0, cfg;
  logic [15:0] tbc, tbe;
  logic [15:0] mdl [4];
  logic [7:0] sh = 0;
  int n_fail = 0, total_checks = 0;
  localparam logic [11:0] A_IDX = 12'h344, A_HI = 12'h348, A_LO = 12'h34c;
  localparam logic [11:0] A_CTL = 12'h350, A_FLG = 12'h354, A_CFG = 12'h358;

  always #20 clk = ~clk;

  tca_capture_array DUT (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .capture_pin(pin), .timer0_overflow(srcs[3]),
    .timer1_overflow(srcs[2]), .comparator_a_event(srcs[1]),
    .comparator_b_event(srcs[0]), .irq(irq), .timebase_count(tbc));

  task stop_test;
    if (n_fail == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test

  task chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    r = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb

  // one-cycle internal trigger; tbe holds the count seen at the capture edge
  // comparator pulses are one-shot pulses driven here on a clock edge, not clocked from the time base
  task pulse(input int s);
    @(posedge clk);
    srcs <= 4'h8 >> (s - 4);
    @(posedge clk);
    tbe = tbc;
    srcs <= 4'h0;
  endtask : pulse

  function automatic logic pin_hit(logic [3:0] c, int ch, int src, logic up);
    if (c[3] || (c[2] && ch >= 2))
      return 1'b0;
    return up ? src != 1 : src != 2;
  endfunction : pin_hit

  initial
  begin
    #(40 * 30000);
    n_fail++;
    stop_test;
  end

  initial
  begin
    void'($urandom(32'h82b401f3));
    repeat (10) @(posedge clk);
    arst_n <= 1;
    apb(0, A_FLG, 0);
    chk(r, 0);
    for (int ch = 0; ch < 4; ch++)
    begin
      v = $urandom;
      apb(1, A_IDX, ch);
      if (ch != 1)
        sh = v[15:8];
      if (ch != 1)
        apb(1, A_HI, v[15:8]);
      apb(1, A_LO, v[7:0]);
      mdl[ch] = {sh, v[7:0]};
    end
    apb(1, A_HI, 8'h5a);
    for (int ch = 0; ch < 4; ch++)
    begin
      apb(1, A_IDX, ch);
      apb(0, A_HI, 0);
      chk(r, mdl[ch][15:8]);
      apb(0, A_LO, 0);
      chk(r, mdl[ch][7:0]);
    end
    apb(1, A_CFG, 1);
    for (int ch = 0; ch < 4; ch++)
    begin
      apb(1, A_IDX, ch);
      apb(1, A_CTL, 4 + ch);
      pulse(4 + ch);
      pulse(4 + ch);
      apb(0, A_LO, 0);
      chk(r, tbe[7:0]);
      apb(0, A_HI, 0);
      chk(r, tbe[15:8]);
      apb(0, A_FLG, 0);
      chk(r, (2 << ch) - 1);
    end
    apb(1, A_IDX, 0);
    apb(1, A_CTL, 8'h14);
    pulse(4);
    @(posedge clk);
    chk(tbc, 0);
    apb(1, A_FLG, 4'hf);
    apb(0, A_FLG, 0);
    chk(r, 4'hf);
    apb(1, A_FLG, 0);
    apb(1, A_CFG, 0);
    pulse(4);
    apb(0, A_FLG, 0);
    chk(r, 0);
    apb(1, A_CFG, 1);
    pulse(4);
    apb(0, 12'h35c, 0);
    chk(r[31:16], 0);
    for (int e = 0; e < 4; e++)
    begin
      apb(1, A_CTL, {e[0], 7'h14});
      apb(1, A_CFG, {e[1], 1'b1});
      @(posedge clk);
      chk(irq, e == 3);
    end
    apb(1, A_FLG, 0);
    @(posedge clk);
    chk(irq, 0);
    for (int c = 0; c < 4; c++)
      for (int src = 1; src < 4; src++)
        for (int ch = 0; ch < 4; ch++)
        begin
          cfg = c == 0 ? 4'h0 : c == 1 ? 4'h1 : c == 2 ? 4'h5 : 4'h9;
          apb(1, A_CFG, cfg);
          apb(1, A_IDX, ch);
          apb(1, A_CTL, src);
          apb(1, A_FLG, 0);
          pin[ch] <= 1;
          repeat (4) @(posedge clk);
          apb(0, A_FLG, 0);
          chk(r, pin_hit(cfg, ch, src, 1) << ch);
          apb(1, A_FLG, 0);
          pin[ch] <= 0;
          repeat (4) @(posedge clk);
          apb(0, A_FLG, 0);
          chk(r, pin_hit(cfg, ch, src, 0) << ch);
        end
    apb(1, A_CFG, 1);
    apb(1, A_FLG, 0);
    pin[3] <= 1;
    @(posedge clk);
    pin[3] <= 0;
    repeat (4) @(posedge clk);
    apb(0, A_FLG, 0);
    chk(r, 0);
    apb(0, 12'h346, 0);
    chk(err, 1);
    chk(r, 0);
    stop_test;
  end
endmodule : tb_top

bind tca_capture_array tca_monitor #(.ADDR_W(ADDR_W)) u_mon (.clk(clk), .arst_n(arst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .capture_pin(capture_pin),
  .timer0_overflow(timer0_overflow), .timer1_overflow(timer1_overflow),
  .comparator_a_event(comparator_a_event), .comparator_b_event(comparator_b_event),
  .irq(irq), .timebase_count(timebase_count));

// ---- tca_capture_array.sv ----
// Design decision made here: register access over APB.
`timescale 1ns/10ps
`include "tca_cfg.svh"

// Notes on behaviour
// - reading the data-high port gives bits 15..8 of the selected channel.
// - data-high writes fill only the shadow; a data-low write moves it in.
// - the shadow survives data-low writes and serves every later one.
// - data-low reads give bits 7..0; writes load shadow and byte as 16 bits.
// - only the indexed channel's data can be read or written.
// - flag register holds channels A..D in bits 0..3, zero after reset.
// - events set a channel flag; only software clears it.
// - a flag interrupts only with its channel enable and the array enable.
// - a channel captures while its compare-select bit is 0.
// - a capture copies the 16-bit time base and sets the flag.
// - with clear-on-event set, a capture also zeroes the time base.
// - channels A..D each have their own capture pin, pins 0..3.
// - pin events are falling, rising or either edge only.
// - pins sampled every clock; a new level must hold two clocks.
// - a new capture overwrites data even if not yet read.
// - internal triggers: timer 0 overflow, timer 1 overflow, comparators.
// - any comparator interrupt condition can serve as a trigger.
// - with converter output on pins 2 and 3, C and D lose pin captures.
// - with the external memory interface active, no pin captures at all.
// - index 00..11 selects channels A..D for the access ports.
// - source 000 off, 001 fall, 010 rise, 011 both, 100 timer 0, 101 timer 1.
// - the interrupt is the OR of all gated channel flags.
// - captures need the run bit; pin events still set flags without it.
module tca_capture_array
  import tca_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] capture_pin,
  input wire logic timer0_overflow,
  input wire logic timer1_overflow,
  input wire logic comparator_a_event,
  input wire logic comparator_b_event,
  output logic irq,
  output logic [15:0] timebase_count
);

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  function automatic tca_sel_t tca_decode(input logic [ADDR_W-1:0] addr);
    logic [9:0] idx;
    idx = 10'(addr >> 2);
    if (addr[1:0] != 2'b00)
      return TCA_SEL_NONE;
    case (idx)
      `TCA_IDX_INDEX: return TCA_SEL_INDEX;
      `TCA_IDX_DATA_HIGH: return TCA_SEL_DATA_HIGH;
      `TCA_IDX_DATA_LOW: return TCA_SEL_DATA_LOW;
      `TCA_IDX_CONTROL: return TCA_SEL_CONTROL;
      `TCA_IDX_FLAGS: return TCA_SEL_FLAGS;
      `TCA_IDX_CONFIG: return TCA_SEL_CONFIG;
      `TCA_IDX_TIMEBASE: return TCA_SEL_TIMEBASE;
      default: return TCA_SEL_NONE;
    endcase
  endfunction : tca_decode

  // ------------------------------------------------------------
  // pin gating by port 2 sharing
  // ------------------------------------------------------------
  function automatic logic tca_pin_allowed(input int ch, input logic [3:0] cfg);
    logic ok;
    ok = 1'b1;
    if (cfg[`TCA_CFG_EXT_MEM])
      ok = 1'b0;
    if (cfg[`TCA_CFG_DAC_ON_P2] && ch >= `TCA_FIRST_DAC_CHANNEL)
      ok = 1'b0;
    return ok;
  endfunction : tca_pin_allowed

  // ------------------------------------------------------------
  // state and pin sampler
  // ------------------------------------------------------------
  tca_state_t st;
  tca_state_t next_st;
  tca_pin_if pin_bus ();
  tca_sel_t sel;
  logic setup_phase;
  logic access_phase;

  assign pin_bus.level = capture_pin;

  tca_pin_sampler u_pin_sampler (
    .clk(clk),
    .arst_n(arst_n),
    .pins(pin_bus)
  );

  assign sel = tca_decode(paddr);
  assign setup_phase = psel & ~penable;
  assign access_phase = psel & penable;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  logic [3:0] trig;
  logic [3:0] pin_trig;
  logic [3:0] flag_set;
  logic tb_clear;
  logic [7:0] ctl_now;
  tca_src_t src;

  always_comb
  begin
    next_st = st;
    trig = 4'h0;
    pin_trig = 4'h0;
    flag_set = 4'h0;
    tb_clear = 1'b0;
    ctl_now = 8'h00;
    src = TCA_SRC_OFF;

    if (st.config_bits[`TCA_CFG_RUN])
      next_st.timebase = st.timebase + 16'h0001;

    // software writes take effect at the access edge
    if (access_phase && pwrite)
    begin
      case (sel)
        TCA_SEL_INDEX:
        begin
          next_st.index = pwdata[1:0];
        end
        TCA_SEL_DATA_HIGH:
        begin
          next_st.shadow = pwdata[7:0];
        end
        TCA_SEL_DATA_LOW:
        begin
          // shadow is reused, never cleared
          next_st.data[st.index] = {st.shadow, pwdata[7:0]};
        end
        TCA_SEL_CONTROL:
        begin
          next_st.control[st.index] = pwdata[7:0] & `TCA_CTL_WRITE_MASK;
        end
        TCA_SEL_FLAGS:
        begin
          next_st.flags = st.flags & pwdata[3:0];
        end
        TCA_SEL_CONFIG:
        begin
          next_st.config_bits = pwdata[3:0];
        end
        default:
        begin
          next_st.index = st.index;
        end
      endcase
    end

    // capture events; they follow the write so a capture overwrites it
    for (int i = 0; i < `TCA_CHANNELS; i++)
    begin
      ctl_now = st.control[i];
      src = tca_src_t'(ctl_now[`TCA_CTL_SRC_HI:`TCA_CTL_SRC_LO]);
      case (src)
        TCA_SRC_FALL: pin_trig[i] = pin_bus.fall[i];
        TCA_SRC_RISE: pin_trig[i] = pin_bus.rise[i];
        TCA_SRC_BOTH: pin_trig[i] = pin_bus.rise[i] | pin_bus.fall[i];
        TCA_SRC_TIMER0: trig[i] = timer0_overflow;
        TCA_SRC_TIMER1: trig[i] = timer1_overflow;
        TCA_SRC_CMP_A: trig[i] = comparator_a_event;
        TCA_SRC_CMP_B: trig[i] = comparator_b_event;
        default: trig[i] = 1'b0;
      endcase
      pin_trig[i] = pin_trig[i] & tca_pin_allowed(i, st.config_bits);
      trig[i] = trig[i] | pin_trig[i];
      if (!ctl_now[`TCA_CTL_COMPARE] && trig[i])
      begin
        if (st.config_bits[`TCA_CFG_RUN])
        begin
          next_st.data[i] = st.timebase;
          flag_set[i] = 1'b1;
          if (ctl_now[`TCA_CTL_CLEAR_TB])
            tb_clear = 1'b1;
        end
        else if (pin_trig[i])
        begin
          flag_set[i] = 1'b1;
        end
      end
    end

    if (tb_clear)
      next_st.timebase = `TCA_TB_CLEAR_VALUE;

    // hardware only sets; a set beats a same-cycle clear
    next_st.flags = next_st.flags | flag_set;

    // read data is captured in the setup cycle
    if (setup_phase)
    begin
      next_st.pslverr = (sel == TCA_SEL_NONE);
      case (sel)
        TCA_SEL_INDEX: next_st.prdata = {30'h0, st.index};
        TCA_SEL_DATA_HIGH: next_st.prdata = {24'h0, st.data[st.index][15:8]};
        TCA_SEL_DATA_LOW: next_st.prdata = {24'h0, st.data[st.index][7:0]};
        TCA_SEL_CONTROL: next_st.prdata = {24'h0, st.control[st.index]};
        TCA_SEL_FLAGS: next_st.prdata = {28'h0, st.flags};
        TCA_SEL_CONFIG: next_st.prdata = {28'h0, st.config_bits};
        TCA_SEL_TIMEBASE: next_st.prdata = {16'h0, st.timebase};
        default: next_st.prdata = 32'h0;
      endcase
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st.index <= `TCA_RST_INDEX;
      st.shadow <= `TCA_RST_SHADOW;
      st.control <= {`TCA_CHANNELS{`TCA_RST_CONTROL}};
      st.data <= {`TCA_CHANNELS{`TCA_RST_DATA}};
      st.flags <= `TCA_RST_FLAGS;
      st.config_bits <= `TCA_RST_CONFIG;
      st.timebase <= `TCA_RST_TIMEBASE;
      st.prdata <= 32'h0;
      st.pslverr <= 1'b0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  logic [3:0] irq_enables;

  always_comb
  begin
    for (int i = 0; i < `TCA_CHANNELS; i++)
      irq_enables[i] = st.control[i][`TCA_CTL_IRQ_EN];
  end

  assign irq = st.config_bits[`TCA_CFG_IRQ_EN] & (|(st.flags & irq_enables));
  assign pready = access_phase;
  assign prdata = st.prdata;
  assign pslverr = st.pslverr & access_phase;
  assign timebase_count = st.timebase;

endmodule : tca_capture_array

// ---- tca_capture_array_monitor.sv ----
`timescale 1ns/10ps

// ------------------------------------------------------------
// port checker
// ------------------------------------------------------------
module tca_monitor
#(
  parameter int ADDR_W = 12
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [3:0] capture_pin,
  input wire logic timer0_overflow,
  input wire logic timer1_overflow,
  input wire logic comparator_a_event,
  input wire logic comparator_b_event,
  input wire logic irq,
  input wire logic [15:0] timebase_count
);
  logic acc;
  logic rd;
  logic cfg_wr;
  assign acc = psel && penable;
  assign rd = acc && !pwrite;
  assign cfg_wr = acc && pwrite && paddr == 'h358;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  AST_READY: assert property (pready == acc)
    else $error("pready not equal to access phase");
  AST_ERR_ACC: assert property (pslverr |-> acc)
    else $error("pslverr outside access phase");
  AST_MISALIGN: assert property (acc && paddr[1:0] != 2'h0 |-> pslverr && prdata == 32'h0)
    else $error("misaligned access not refused");
  AST_TB_READ: assert property (rd && paddr == 'h35c |-> prdata == {16'h0, $past(timebase_count)})
    else $error("time base read wrong");
  AST_TB_STEP: assert property (timebase_count == 16'h0 || $stable(timebase_count)
    || timebase_count == $past(timebase_count) + 16'h1)
    else $error("time base jumped");
  AST_IRQ_GATE: assert property (cfg_wr && !pwdata[1] |=> !irq)
    else $error("irq without array enable");
  AST_RUN0: assert property (cfg_wr && !pwdata[0] |=> ##1 $stable(timebase_count))
    else $error("time base moves while stopped");
  AST_FLAG_HI: assert property (rd && paddr == 'h354 |-> prdata[31:4] == 28'h0)
    else $error("flag upper bits not zero");
  AST_DATA_HI: assert property (rd && (paddr == 'h348 || paddr == 'h34c)
    |-> prdata[31:8] == 24'h0)
    else $error("data port upper bits not zero");
  COV_IRQ: cover property (irq);
  COV_ERR: cover property (pslverr);
  COV_CLR: cover property (timebase_count != 16'h0 ##1 timebase_count == 16'h0);
endmodule : tca_monitor

// ---- tca_cfg.svh ----
`ifndef TCA_CFG_SVH
`define TCA_CFG_SVH

// ------------------------------------------------------------
// register indices (byte address is four times the index)
// ------------------------------------------------------------
`define TCA_IDX_INDEX 10'h0d1
`define TCA_IDX_DATA_HIGH 10'h0d2
`define TCA_IDX_DATA_LOW 10'h0d3
`define TCA_IDX_CONTROL 10'h0d4
`define TCA_IDX_FLAGS 10'h0d5
`define TCA_IDX_CONFIG 10'h0d6
`define TCA_IDX_TIMEBASE 10'h0d7

// ------------------------------------------------------------
// channel control word fields
// ------------------------------------------------------------
`define TCA_CTL_IRQ_EN 7
`define TCA_CTL_DIR 6
`define TCA_CTL_CLEAR_TB 4
`define TCA_CTL_COMPARE 3
`define TCA_CTL_SRC_HI 2
`define TCA_CTL_SRC_LO 0
`define TCA_CTL_WRITE_MASK 8'h9f

// ------------------------------------------------------------
// array configuration fields
// ------------------------------------------------------------
`define TCA_CFG_RUN 0
`define TCA_CFG_IRQ_EN 1
`define TCA_CFG_DAC_ON_P2 2
`define TCA_CFG_EXT_MEM 3

// ------------------------------------------------------------
// reset values and counts
// ------------------------------------------------------------
`define TCA_RST_INDEX 2'h0
`define TCA_RST_SHADOW 8'h00
`define TCA_RST_CONTROL 8'h00
`define TCA_RST_DATA 16'h0000
`define TCA_RST_FLAGS 4'h0
`define TCA_RST_CONFIG 4'h0
`define TCA_RST_TIMEBASE 16'h0000
`define TCA_TB_CLEAR_VALUE 16'h0000
`define TCA_CHANNELS 4
`define TCA_PIN_STABLE_CYCLES 2
`define TCA_FIRST_DAC_CHANNEL 2

`endif

// ---- tca_pin_if.sv ----
`timescale 1ns/10ps

// ------------------------------------------------------------
// capture pin levels and their qualified edges
// ------------------------------------------------------------
interface tca_pin_if;
  logic [3:0] level;
  logic [3:0] rise;
  logic [3:0] fall;

  modport sampler (input level, output rise, output fall);
  modport user (output level, input rise, input fall);
endinterface : tca_pin_if

// ---- tca_pin_sampler.sv ----
`timescale 1ns/10ps
`include "tca_cfg.svh"

// ------------------------------------------------------------
// pin sampler: a level must be seen on two edges before it counts
// ------------------------------------------------------------
module tca_pin_sampler
  import tca_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  tca_pin_if.sampler pins
);

  tca_pin_state_t st;
  tca_pin_state_t next_st;

  always_comb
  begin
    next_st = st;
    next_st.sample = pins.level;
    next_st.rise = 4'h0;
    next_st.fall = 4'h0;
    next_st.primed = 1'b1;
    if (!st.primed)
    begin
      // first sample after reset is taken as the idle level
      next_st.stable = pins.level;
    end
    else
    begin
      for (int i = 0; i < `TCA_CHANNELS; i++)
      begin
        // new level held across two samples is accepted
        if (pins.level[i] == st.sample[i] && pins.level[i] != st.stable[i])
        begin
          next_st.stable[i] = pins.level[i];
          next_st.rise[i] = pins.level[i];
          next_st.fall[i] = ~pins.level[i];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      st <= '0;
    else
      st <= next_st;
  end

  assign pins.rise = st.rise;
  assign pins.fall = st.fall;

endmodule : tca_pin_sampler

// ---- tca_pkg.sv ----
package tca_pkg;

  // ------------------------------------------------------------
  // register select
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    TCA_SEL_NONE = 3'b000,
    TCA_SEL_INDEX = 3'b001,
    TCA_SEL_DATA_HIGH = 3'b010,
    TCA_SEL_DATA_LOW = 3'b011,
    TCA_SEL_CONTROL = 3'b100,
    TCA_SEL_FLAGS = 3'b101,
    TCA_SEL_CONFIG = 3'b110,
    TCA_SEL_TIMEBASE = 3'b111
  } tca_sel_t;

  // ------------------------------------------------------------
  // capture event source
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    TCA_SRC_OFF = 3'b000,
    TCA_SRC_FALL = 3'b001,
    TCA_SRC_RISE = 3'b010,
    TCA_SRC_BOTH = 3'b011,
    TCA_SRC_TIMER0 = 3'b100,
    TCA_SRC_TIMER1 = 3'b101,
    TCA_SRC_CMP_A = 3'b110,
    TCA_SRC_CMP_B = 3'b111
  } tca_src_t;

  // ------------------------------------------------------------
  // state records
  // ------------------------------------------------------------
  typedef struct packed {
    logic [1:0] index;
    logic [7:0] shadow;
    logic [3:0][7:0] control;
    logic [3:0][15:0] data;
    logic [3:0] flags;
    logic [3:0] config_bits;
    logic [15:0] timebase;
    logic [31:0] prdata;
    logic pslverr;
  } tca_state_t;

  typedef struct packed {
    logic primed;
    logic [3:0] sample;
    logic [3:0] stable;
    logic [3:0] rise;
    logic [3:0] fall;
  } tca_pin_state_t;

endpackage : tca_pkg
